// [design/isg_pkg.sv]
// isg_pkg: constants for the interrupt status and enable gating block.
// assumes one clock domain and register access by device-control-register number.
package isg_pkg;
   localparam int ISG_DATA_W = 32;
   localparam int ISG_ADDR_W = 10;
   // register numbers as seen on the control-register bus
   localparam logic [9:0] ISG_STATUS_ADDR = 10'h0C0;
   localparam logic [9:0] ISG_ENABLE_ADDR = 10'h0C2;
   localparam logic [9:0] ISG_CLASS_ADDR = 10'h0C3;
   // reset values
   localparam logic [31:0] ISG_STATUS_RST = 32'h00000000;
   localparam logic [31:0] ISG_ENABLE_RST = 32'h00000000;
   localparam logic [31:0] ISG_CLASS_RST = 32'h00000000;
   // positions 4 and 24 are reserved
   localparam logic [31:0] ISG_IMPL_MASK = 32'hFEFFFFEF;
   // field positions
   localparam int ISG_SERIAL_A_POS = 0;
   localparam int ISG_SERIAL_B_POS = 1;
   localparam int ISG_TWO_WIRE_POS = 2;
   localparam int ISG_PCI_CMD_POS = 3;
   localparam int ISG_DMA0_POS = 5;
   localparam int ISG_DMA2_POS = 7;
   localparam int ISG_DMA3_POS = 8;
   localparam int ISG_WAKE_POS = 9;
   localparam int ISG_MEM_LAYER_POS = 10;
   localparam int ISG_MAC_A_POS = 15;
   localparam int ISG_PCI_SYSERR_POS = 16;
   localparam int ISG_MAC_B_POS = 17;
   localparam int ISG_PCI_POWER_POS = 18;
   localparam int ISG_TIMER_POS = 19;
   localparam int ISG_EXT_REQ_POS = 25;
   // source counts
   localparam int ISG_DMA_N = 4;
   localparam int ISG_MEM_LAYER_N = 5;
   localparam int ISG_TIMER_N = 5;
   localparam int ISG_EXT_REQ_N = 7;
   // pin inputs pass four flip-flops
   localparam int ISG_PIN_N = ISG_EXT_REQ_N + 1;
endpackage

// [design/isg_gating.sv]
// isg_gating: sticky interrupt status, per-source enable and class routing to the core.
// assumes a device-control-register slave port on clk_sys; ext pins and the serr pin are asynchronous.
// Contract
// - each enable bit gates its own status bit
// - enabled and pending source raises core request
// - disabled source never raises a request
// - class register picks critical or non-critical output
// - dma2 at 7, dma3 at 8
// - ethernet wake-up at position 9
// - memory layer errors at positions 10 to 14
// - mac a at 15, mac b at 17
// - pci syserr pin sets position 16
// - pci power management at position 18
// - five timers at positions 19 to 23
// - seven external requests at 25 to 31
// - enables for serials and two-wire at 0..2
// - pci command write enable at position 3
// - dma0 enable at position 5
// - status sticky, write one clears, zero ignored
// - capture ignores enable and class contents
`timescale 1ns/1ns
module isg_gating
   import isg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // control-register bus
   input wire logic dcr_read,
   input wire logic dcr_write,
   input wire logic [ISG_ADDR_W-1:0] dcr_addr,
   input wire logic [ISG_DATA_W-1:0] dcr_wdata,
   output logic [ISG_DATA_W-1:0] dcr_rdata,
   output logic dcr_ack,
   // on-chip sources, active high levels on clk_sys
   input wire logic serial_a_irq,
   input wire logic serial_b_irq,
   input wire logic two_wire_irq,
   input wire logic pci_cmd_write_irq,
   input wire logic [ISG_DMA_N-1:0] dma_irq,
   input wire logic wake_irq,
   input wire logic [ISG_MEM_LAYER_N-1:0] mem_layer_irq,
   input wire logic mac_a_irq,
   input wire logic mac_b_irq,
   input wire logic pci_power_irq,
   input wire logic [ISG_TIMER_N-1:0] timer_irq,
   // asynchronous pins
   input wire logic pci_serr_n,
   input wire logic [ISG_EXT_REQ_N-1:0] ext_irq,
   // core request outputs
   output logic crit_irq,
   output logic noncrit_irq
);
   logic [ISG_PIN_N-1:0] pin_s1_reg;
   logic [ISG_PIN_N-1:0] pin_s2_reg;
   logic [ISG_PIN_N-1:0] pin_s3_reg;
   logic [ISG_PIN_N-1:0] pin_level_reg;
   logic [ISG_PIN_N-1:0] pin_level_next;
   logic [31:0] status_reg;
   logic [31:0] status_next;
   logic [31:0] enable_reg;
   logic [31:0] enable_next;
   logic [31:0] class_reg;
   logic [31:0] class_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;
   wire [31:0] src_vec;
   wire [31:0] pending_vec;
   wire [31:0] clear_vec;
   wire hit_status;
   wire hit_enable;
   wire hit_class;
   wire hit_any;
   wire access;
   wire wr_status;
   wire wr_enable;
   wire wr_class;

   // a pin change counts only once two later stages agree, so a metastable first stage never leaks
   assign pin_level_next = (pin_s2_reg ~^ pin_s3_reg) & pin_s3_reg | ~(pin_s2_reg ~^ pin_s3_reg) & pin_level_reg;

   always_ff @(posedge clk_sys) begin
      pin_s1_reg <= {pci_serr_n, ext_irq};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (srst) begin
         pin_level_reg <= {1'b1, {ISG_EXT_REQ_N{1'b0}}};
      end else begin
         pin_level_reg <= pin_level_next;
      end
   end

   // source map; reserved positions tied low
   assign src_vec[ISG_SERIAL_A_POS] = serial_a_irq;
   assign src_vec[ISG_SERIAL_B_POS] = serial_b_irq;
   assign src_vec[ISG_TWO_WIRE_POS] = two_wire_irq;
   assign src_vec[ISG_PCI_CMD_POS] = pci_cmd_write_irq;
   assign src_vec[4] = 1'b0;
   assign src_vec[ISG_DMA0_POS +: ISG_DMA_N] = dma_irq;
   assign src_vec[ISG_WAKE_POS] = wake_irq;
   assign src_vec[ISG_MEM_LAYER_POS +: ISG_MEM_LAYER_N] = mem_layer_irq;
   assign src_vec[ISG_MAC_A_POS] = mac_a_irq;
   assign src_vec[ISG_PCI_SYSERR_POS] = ~pin_level_reg[ISG_EXT_REQ_N];
   assign src_vec[ISG_MAC_B_POS] = mac_b_irq;
   assign src_vec[ISG_PCI_POWER_POS] = pci_power_irq;
   assign src_vec[ISG_TIMER_POS +: ISG_TIMER_N] = timer_irq;
   assign src_vec[24] = 1'b0;
   assign src_vec[ISG_EXT_REQ_POS +: ISG_EXT_REQ_N] = pin_level_reg[ISG_EXT_REQ_N-1:0];

   // one compare per register number, shared by every decode below
   function automatic logic isg_addr_hit(input logic [ISG_ADDR_W-1:0] addr, input logic [ISG_ADDR_W-1:0] num);
      isg_addr_hit = (addr == num);
   endfunction

   // address decode; unmapped numbers get no ack so another slave may answer
   assign hit_status = isg_addr_hit(dcr_addr, ISG_STATUS_ADDR);
   assign hit_enable = isg_addr_hit(dcr_addr, ISG_ENABLE_ADDR);
   assign hit_class = isg_addr_hit(dcr_addr, ISG_CLASS_ADDR);
   assign hit_any = hit_status | hit_enable | hit_class;
   assign access = (dcr_read | dcr_write) & hit_any & ~ack_reg;
   assign wr_status = access & dcr_write & hit_status;
   assign wr_enable = access & dcr_write & hit_enable;
   assign wr_class = access & dcr_write & hit_class;

   // write one clears; a source still high in the same cycle wins over the clear
   assign clear_vec = wr_status ? dcr_wdata : 32'h00000000;
   assign status_next = ((status_reg & ~clear_vec) | src_vec) & ISG_IMPL_MASK;
   assign enable_next = wr_enable ? (dcr_wdata & ISG_IMPL_MASK) : enable_reg;
   assign class_next = wr_class ? (dcr_wdata & ISG_IMPL_MASK) : class_reg;
   // read returns the value before this cycle's update
   assign rdata_next = ~(access & dcr_read) ? 32'h00000000 :
                       hit_status ? status_reg :
                       hit_enable ? enable_reg : class_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_reg <= ISG_STATUS_RST;
         enable_reg <= ISG_ENABLE_RST;
         class_reg <= ISG_CLASS_RST;
         rdata_reg <= 32'h00000000;
         ack_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         enable_reg <= enable_next;
         class_reg <= class_next;
         rdata_reg <= rdata_next;
         ack_reg <= access;
      end
   end

   assign dcr_rdata = rdata_reg;
   assign dcr_ack = ack_reg;

   // the core masks these further by its own state register, outside this block
   assign pending_vec = status_reg & enable_reg;
   assign crit_irq = |(pending_vec & class_reg);
   assign noncrit_irq = |(pending_vec & ~class_reg);

   property p_disabled_silent;
      @(posedge clk_sys) disable iff (srst)
      (pending_vec == 32'h00000000) |-> (!crit_irq && !noncrit_irq);
   endproperty
   a_disabled_silent: assert property (p_disabled_silent) else $error("request without enabled status");

   property p_enabled_raises;
      @(posedge clk_sys) disable iff (srst)
      (status_reg[ISG_DMA0_POS] && enable_reg[ISG_DMA0_POS]) |-> (crit_irq || noncrit_irq);
   endproperty
   a_enabled_raises: assert property (p_enabled_raises) else $error("enabled pending source not reported");

   property p_class_routes;
      @(posedge clk_sys) disable iff (srst)
      (|(pending_vec & ~class_reg)) |-> noncrit_irq ##0 (crit_irq == (|(pending_vec & class_reg)));
   endproperty
   a_class_routes: assert property (p_class_routes) else $error("class routing wrong");

   property p_capture_dma2;
      @(posedge clk_sys) disable iff (srst)
      dma_irq[2] |=> status_reg[ISG_DMA2_POS];
   endproperty
   a_capture_dma2: assert property (p_capture_dma2) else $error("dma2 status not captured");

   property p_capture_timer4;
      @(posedge clk_sys) disable iff (srst)
      (timer_irq[4] && enable_reg == 32'h00000000) |=> status_reg[23];
   endproperty
   a_capture_timer4: assert property (p_capture_timer4) else $error("timer4 status not captured");

   property p_ext_pin;
      @(posedge clk_sys) disable iff (srst)
      ext_irq[0] [*5] |=> status_reg[ISG_EXT_REQ_POS];
   endproperty
   a_ext_pin: assert property (p_ext_pin) else $error("external request 0 not captured");

   property p_serr_pin;
      @(posedge clk_sys) disable iff (srst)
      !pci_serr_n [*5] |=> status_reg[ISG_PCI_SYSERR_POS];
   endproperty
   a_serr_pin: assert property (p_serr_pin) else $error("pci syserr not captured");

   property p_sticky;
      @(posedge clk_sys) disable iff (srst)
      (status_reg[ISG_WAKE_POS] && !wr_status) |=> status_reg[ISG_WAKE_POS];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit lost without clear");

   property p_clear;
      @(posedge clk_sys) disable iff (srst)
      (wr_status && dcr_wdata[ISG_MAC_A_POS] && !mac_a_irq) |=> !status_reg[ISG_MAC_A_POS];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear");

   property p_reserved;
      @(posedge clk_sys) disable iff (srst)
      (!status_reg[4] && !status_reg[24] && !enable_reg[4] && !enable_reg[24] && !class_reg[4] && !class_reg[24]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved position nonzero");

   property p_enable_write;
      @(posedge clk_sys) disable iff (srst)
      wr_enable |=> (enable_reg[3:0] == $past(dcr_wdata[3:0]) && enable_reg[5] == $past(dcr_wdata[5]));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

   property p_capture_dma3;
      @(posedge clk_sys) disable iff (srst)
      dma_irq[3] |=> status_reg[ISG_DMA3_POS];
   endproperty
   a_capture_dma3: assert property (p_capture_dma3) else $error("dma3 status not captured");

   property p_capture_wake;
      @(posedge clk_sys) disable iff (srst)
      wake_irq |=> status_reg[ISG_WAKE_POS];
   endproperty
   a_capture_wake: assert property (p_capture_wake) else $error("wake status not captured");

   property p_capture_mem_layer;
      @(posedge clk_sys) disable iff (srst)
      mem_layer_irq[4] |=> status_reg[ISG_MEM_LAYER_POS + 4];
   endproperty
   a_capture_mem_layer: assert property (p_capture_mem_layer) else $error("memory layer status not captured");

   property p_capture_mac_b;
      @(posedge clk_sys) disable iff (srst)
      mac_b_irq |=> status_reg[ISG_MAC_B_POS];
   endproperty
   a_capture_mac_b: assert property (p_capture_mac_b) else $error("mac b status not captured");

   property p_capture_power;
      @(posedge clk_sys) disable iff (srst)
      pci_power_irq |=> status_reg[ISG_PCI_POWER_POS];
   endproperty
   a_capture_power: assert property (p_capture_power) else $error("pci power status not captured");

   property p_ext_pin6;
      @(posedge clk_sys) disable iff (srst)
      ext_irq[6] [*5] |=> status_reg[ISG_EXT_REQ_POS + 6];
   endproperty
   a_ext_pin6: assert property (p_ext_pin6) else $error("external request 6 not captured");

   property p_capture_unenabled;
      @(posedge clk_sys) disable iff (srst)
      (serial_b_irq && !enable_reg[ISG_SERIAL_B_POS]) |=> status_reg[ISG_SERIAL_B_POS];
   endproperty
   a_capture_unenabled: assert property (p_capture_unenabled) else $error("capture depended on enable");

   property p_two_wire_raises;
      @(posedge clk_sys) disable iff (srst)
      (status_reg[ISG_TWO_WIRE_POS] && enable_reg[ISG_TWO_WIRE_POS]) |-> (crit_irq || noncrit_irq);
   endproperty
   a_two_wire_raises: assert property (p_two_wire_raises) else $error("two-wire request not reported");

   property p_pci_cmd_raises;
      @(posedge clk_sys) disable iff (srst)
      (status_reg[ISG_PCI_CMD_POS] && enable_reg[ISG_PCI_CMD_POS]) |-> (crit_irq || noncrit_irq);
   endproperty
   a_pci_cmd_raises: assert property (p_pci_cmd_raises) else $error("pci command request not reported");

   property p_crit_source;
      @(posedge clk_sys) disable iff (srst)
      crit_irq |-> (|(status_reg & enable_reg & class_reg));
   endproperty
   a_crit_source: assert property (p_crit_source) else $error("critical request without critical source");

   property p_noncrit_source;
      @(posedge clk_sys) disable iff (srst)
      noncrit_irq |-> (|(status_reg & enable_reg & ~class_reg));
   endproperty
   a_noncrit_source: assert property (p_noncrit_source) else $error("non-critical request without source");

   property p_class_write;
      @(posedge clk_sys) disable iff (srst)
      wr_class |=> (class_reg == ($past(dcr_wdata) & ISG_IMPL_MASK));
   endproperty
   a_class_write: assert property (p_class_write) else $error("class write not stored");

   property p_zero_write;
      @(posedge clk_sys) disable iff (srst)
      (wr_status && !dcr_wdata[ISG_DMA2_POS] && status_reg[ISG_DMA2_POS]) |=> status_reg[ISG_DMA2_POS];
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write cleared a status bit");

   property p_reset_values;
      @(posedge clk_sys)
      srst |=> (status_reg == ISG_STATUS_RST && enable_reg == ISG_ENABLE_RST && !crit_irq && !noncrit_irq);
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("request or register live after reset");
endmodule

// [test/isg_core_model.sv]
// isg_core_model: core side that accepts or ignores the two request levels.
// assumes the requests are levels on clk_sys.
`timescale 1ns/1ns
module isg_core_model (
   // clock
   input wire logic clk_sys,
   // requests from the controller
   input wire logic crit_irq,
   input wire logic noncrit_irq,
   // core state-register enables
   input wire logic crit_en,
   input wire logic noncrit_en,
   // accepted requests
   output logic crit_taken,
   output logic noncrit_taken
);
   // masking by core state is the core's job, the controller never sees it
   always_ff @(posedge clk_sys) begin
      crit_taken <= crit_irq & crit_en;
      noncrit_taken <= noncrit_irq & noncrit_en;
   end
endmodule

// [test/isg_gating_tb.sv]
// isg_gating_tb: register, capture and gating tests of the interrupt block.
// assumes every mapped access is acknowledged within eight cycles.
`timescale 1ns/1ns
module isg_gating_tb;
   import isg_pkg::*;
   logic clk_sys, srst, dcr_read, dcr_write, dcr_ack, crit_irq, noncrit_irq;
   logic crit_en, noncrit_en, crit_taken, noncrit_taken, got;
   logic [ISG_ADDR_W-1:0] dcr_addr;
   logic [31:0] dcr_wdata, dcr_rdata, src, rd, exp;
   int error_cnt = 0;
   int n_compared = 0;

   isg_gating dut (.clk_sys(clk_sys), .srst(srst), .dcr_read(dcr_read), .dcr_write(dcr_write),
      .dcr_addr(dcr_addr), .dcr_wdata(dcr_wdata), .dcr_rdata(dcr_rdata), .dcr_ack(dcr_ack),
      .serial_a_irq(src[0]), .serial_b_irq(src[1]), .two_wire_irq(src[2]), .pci_cmd_write_irq(src[3]),
      .dma_irq(src[8:5]), .wake_irq(src[9]), .mem_layer_irq(src[14:10]), .mac_a_irq(src[15]),
      .mac_b_irq(src[17]), .pci_power_irq(src[18]), .timer_irq(src[23:19]), .pci_serr_n(~src[16]),
      .ext_irq(src[31:25]), .crit_irq(crit_irq), .noncrit_irq(noncrit_irq));
   isg_core_model core (.clk_sys(clk_sys), .crit_irq(crit_irq), .noncrit_irq(noncrit_irq),
      .crit_en(crit_en), .noncrit_en(noncrit_en), .crit_taken(crit_taken), .noncrit_taken(noncrit_taken));

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] a);
      n_compared++;
      if (a !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, e, a);
      end
   endtask
   // request held from a falling edge until the ack cycle, dropped there
   task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d, output logic ok);
      ok = 1'b0;
      @(negedge clk_sys);
      dcr_read = ~w;
      dcr_write = w;
      dcr_addr = a;
      dcr_wdata = d;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clk_sys);
         if (dcr_ack === 1'b1) begin
            ok = 1'b1;
            rd = dcr_rdata;
         end
      end
      dcr_read = 1'b0;
      dcr_write = 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      acc(1'b1, a, d, got);
      chk("write ack", 32'h1, {31'h0, got});
   endtask
   task automatic rdc(input string name, input logic [9:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, got);
      chk("read ack", 32'h1, {31'h0, got});
      chk(name, e, rd);
   endtask
   task automatic irq(input logic [1:0] e);
      chk("crit noncrit", {30'h0, e}, {30'h0, crit_irq, noncrit_irq});
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // about 1000 cycles are needed; the limit leaves five times that
   initial begin
      #(40 * 5000);
      error_cnt++;
      conclude();
   end
   initial begin
      srst = 1'b1;
      dcr_read = 1'b0;
      dcr_write = 1'b0;
      dcr_addr = '0;
      dcr_wdata = '0;
      src = '0;
      crit_en = 1'b1;
      noncrit_en = 1'b1;
      repeat (10) @(negedge clk_sys);
      srst = 1'b0;
      rdc("status", ISG_STATUS_ADDR, 32'h0);
      rdc("enable", ISG_ENABLE_ADDR, 32'h0);
      rdc("class", ISG_CLASS_ADDR, 32'h0);
      acc(1'b0, 10'h0C1, 32'h0, got);
      chk("unmapped ack", 32'h0, {31'h0, got});
      wr(ISG_ENABLE_ADDR, 32'hFFFFFFFF);
      rdc("enable all", ISG_ENABLE_ADDR, 32'hFEFFFFEF);
      wr(ISG_ENABLE_ADDR, 32'h0);
      wr(ISG_CLASS_ADDR, 32'hFFFFFFFF);
      rdc("class all", ISG_CLASS_ADDR, 32'hFEFFFFEF);
      wr(ISG_CLASS_ADDR, 32'h0);
      $display("test registers done");
      // every position, enables off: capture must not care
      for (int p = 0; p < 32; p++) begin
         src[p] = 1'b1;
         repeat (8) @(negedge clk_sys);
         src[p] = 1'b0;
         repeat (6) @(negedge clk_sys);
         exp = (p == 4 || p == 24) ? 32'h0 : 32'h1 << p;
         rdc($sformatf("status bit %0d", p), ISG_STATUS_ADDR, exp);
         irq(2'b00);
         wr(ISG_ENABLE_ADDR, ~(32'h1 << p));
         irq(2'b00);
         wr(ISG_ENABLE_ADDR, 32'h1 << p);
         irq((p == 4 || p == 24) ? 2'b00 : 2'b01);
         wr(ISG_ENABLE_ADDR, 32'h0);
         wr(ISG_STATUS_ADDR, 32'hFFFFFFFF);
         rdc("status cleared", ISG_STATUS_ADDR, 32'h0);
      end
      $display("test capture done");
      crit_en = 1'b0;
      src[7] = 1'b1;
      repeat (6) @(negedge clk_sys);
      irq(2'b00);
      wr(ISG_ENABLE_ADDR, 32'h00000100);
      irq(2'b00);
      wr(ISG_ENABLE_ADDR, 32'h00000080);
      irq(2'b01);
      @(negedge clk_sys);
      chk("core noncrit", 32'h1, {31'h0, noncrit_taken});
      wr(ISG_CLASS_ADDR, 32'h00000080);
      irq(2'b10);
      @(negedge clk_sys);
      chk("core crit", 32'h0, {31'h0, crit_taken});
      wr(ISG_STATUS_ADDR, 32'h00000080);
      rdc("status held", ISG_STATUS_ADDR, 32'h80);
      src[7] = 1'b0;
      wr(ISG_STATUS_ADDR, 32'h0);
      rdc("status zero write", ISG_STATUS_ADDR, 32'h80);
      wr(ISG_STATUS_ADDR, 32'h00000080);
      irq(2'b00);
      $display("test gating done");
      src[7] = 1'b1;
      repeat (2) @(negedge clk_sys);
      irq(2'b10);
      srst = 1'b1;
      src[7] = 1'b0;
      repeat (4) @(negedge clk_sys);
      srst = 1'b0;
      irq(2'b00);
      rdc("status after reset", ISG_STATUS_ADDR, 32'h0);
      rdc("enable after reset", ISG_ENABLE_ADDR, 32'h0);
      rdc("class after reset", ISG_CLASS_ADDR, 32'h0);
      $display("test reset done");
      conclude();
   end
endmodule
